//--- rtl/twe_front_end.sv
// Two-wire serial slave front end: framing, addressing, acknowledge, write busy.
// Assumes scl and sda come straight from pins; received words leave through a
// two-entry buffer with valid/ready toward logic on clk.

// Summary of operation
// - Data changes only with clock low.
// - Falling data, clock high, is start.
// - Rising data, clock high, is stop.
// - Stop after read enters standby.
// - Eight-bit words, acknowledged on ninth clock.
// - Standby at power-up, after stop with no data written, and after internal write.
// - Device address word follows every start.
// - Four top bits must match preamble.
// - Next three bits match select pins.
// - Unconnected select pin reads as low.
// - Lowest address bit: one read, zero write.
// - Match acknowledges; mismatch returns to standby.
// - Internal write lasts at most 5 ms.
// - No acknowledge during internal write.
// - Sample on rising, shift on falling.
// - Data line only pulled low or released.
module twe_front_end
  import twe_pkg::*;
#(
  parameter logic [TMR_W-1:0] WR_CYCLES = TMR_W'(WR_CYCLES_DEF)
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       chip_select_bit2,
  input  wire logic       chip_select_bit1,
  input  wire logic       chip_select_bit0,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic            standby,
  output logic            write_busy
);

  typedef struct packed {
    logic bit_v;
    logic tgl;
  } twe_link_t;

  typedef struct packed {
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_p;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_p;
    logic             tgl_s1;
    logic             tgl_s2;
    logic             tgl_p;
    logic [2:0]       cs_s1;
    logic [2:0]       cs_s2;
    twe_state_t       st;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic             ack_pend;
    logic             in_ack;
    logic             oe;
    logic             rw;
    logic             wrote;
    logic [TMR_W-1:0] tmr;
    logic [7:0]       head;
    logic             head_v;
    logic [7:0]       tail;
    logic             tail_v;
    logic             standby;
    logic             busy;
  } twe_core_t;

  twe_link_t lk_q;
  twe_link_t lk_d;
  twe_core_t q;
  twe_core_t d;

  logic       start_ev;
  logic       stop_ev;
  logic       rise_ev;
  logic       fall_ev;
  logic       addr_match;
  logic       last_bit;
  logic [7:0] word;

  // Link domain: each rising serial clock captures one bit and flips a toggle.
  // The bit holds until the next rising edge, far longer than the crossing.
  always_comb begin
    lk_d       = lk_q;
    lk_d.bit_v = sda_i;
    lk_d.tgl   = ~lk_q.tgl;
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign start_ev = q.scl_p & q.scl_s2 & q.sda_p & ~q.sda_s2;
  assign stop_ev  = q.scl_p & q.scl_s2 & ~q.sda_p & q.sda_s2;
  assign rise_ev  = q.tgl_s2 ^ q.tgl_p;
  assign fall_ev  = q.scl_p & ~q.scl_s2;
  assign word     = {q.sh[6:0], lk_q.bit_v};
  assign last_bit = rise_ev & (q.cnt == BIT_LAST);
  // floating pins are pulled low outside
  assign addr_match = (word[PRE_MSB:PRE_LSB] == DEV_PREAMBLE) &&
                      (word[CS_MSB:CS_LSB] == q.cs_s2);

  always_comb begin
    d        = q;
    d.scl_s1 = scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;
    d.tgl_s1 = lk_q.tgl;
    d.tgl_s2 = q.tgl_s1;
    d.tgl_p  = q.tgl_s2;
    d.cs_s1  = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
    d.cs_s2  = q.cs_s1;

    // Pop first, so a word landing this cycle takes a freed head; the full check still uses the old tail
    if (q.head_v && rx_ready) begin
      d.head_v = q.tail_v;
      d.head   = q.tail;
      d.tail_v = 1'b0;
    end

    case (q.st)
      ST_ADDR, ST_DATA: begin
        if (rise_ev) begin
          if (q.cnt == BIT_ACK) begin
            // Ninth clock: master's level here is not data
            d.cnt = CNT_RST;
          end else begin
            d.sh  = word;
            d.cnt = q.cnt + 4'h1;
          end
          if (last_bit && q.st == ST_ADDR) begin
            // ack on match, else drop out
            if (addr_match) begin
              d.ack_pend = 1'b1;
              d.rw       = word[RW_POS];
            end else begin
              // silent until next start
              // Standby wakes only on a start, so bits pass unseen
              d.st = ST_STANDBY;
            end
          end else if (last_bit && !q.tail_v) begin
            // Full buffer refuses the word with no ack, so none is lost
            d.ack_pend = 1'b1;
            d.wrote    = 1'b1;
            if (d.head_v) begin
              d.tail   = word;
              d.tail_v = 1'b1;
            end else begin
              d.head   = word;
              d.head_v = 1'b1;
            end
          end
        end else if (fall_ev) begin
          if (q.ack_pend) begin
            d.oe       = 1'b1;
            d.ack_pend = 1'b0;
            d.in_ack   = 1'b1;
          end else if (q.in_ack && q.cnt == CNT_RST) begin
            d.oe     = 1'b0;
            d.in_ack = 1'b0;
            // Leave address phase only with scl low, else release looks like stop
            if (q.st == ST_ADDR) begin
              // read goes quiet, write takes data
              d.st = q.rw ? ST_IGNORE : ST_DATA;
            end
          end
        end
      end
      ST_WRITE: begin
        if (q.tmr == WR_CYCLES - TMR_W'(1)) begin
          d.st = ST_STANDBY;
        end else begin
          d.tmr = q.tmr + TMR_W'(1);
        end
      end
      default: begin
      end
    endcase

    if (q.st != ST_WRITE) begin
      if (start_ev) begin
        d.st       = ST_ADDR;
        d.cnt      = CNT_RST;
        d.oe       = 1'b0;
        d.ack_pend = 1'b0;
        d.in_ack   = 1'b0;
        d.rw       = 1'b0;
        d.wrote    = 1'b0;
      end else if (stop_ev) begin
        d.st       = (q.st == ST_DATA && q.wrote) ? ST_WRITE : ST_STANDBY;
        d.tmr      = TMR_RST;
        d.cnt      = CNT_RST;
        d.oe       = 1'b0;
        d.ack_pend = 1'b0;
        d.in_ack   = 1'b0;
      end
    end

    d.standby = (d.st == ST_STANDBY);
    d.busy    = (d.st == ST_WRITE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.scl_s1   <= 1'b1;
      q.scl_s2   <= 1'b1;
      q.scl_p    <= 1'b1;
      q.sda_s1   <= 1'b1;
      q.sda_s2   <= 1'b1;
      q.sda_p    <= 1'b1;
      q.cs_s1    <= CS_RST;
      q.cs_s2    <= CS_RST;
      q.st       <= ST_STANDBY;
      q.sh       <= BYTE_RST;
      q.tmr      <= TMR_RST;
      q.standby  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // open drain, low or released only
  assign sda_o      = 1'b0;
  assign sda_oe     = q.oe;
  assign rx_data    = q.head;
  assign rx_valid   = q.head_v;
  assign standby    = q.standby;
  assign write_busy = q.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ack_on_fall_a: assert property (
    q.ack_pend && fall_ev && (q.st == ST_ADDR || q.st == ST_DATA) |=> sda_oe && q.in_ack)
    else $error("ack not driven on falling clock");

  oe_phase_a: assert property (
    sda_oe |-> q.in_ack && (q.st == ST_ADDR || q.st == ST_DATA))
    else $error("data line pulled outside acknowledge");

  start_addr_a: assert property (
    start_ev && q.st != ST_WRITE |=> q.st == ST_ADDR && q.cnt == CNT_RST && !sda_oe)
    else $error("start did not open address phase");

  stop_idle_a: assert property (
    stop_ev && q.st != ST_WRITE && !(q.st == ST_DATA && q.wrote) |=> standby)
    else $error("stop did not reach standby");

  stop_write_a: assert property (
    stop_ev && q.st == ST_DATA && q.wrote |=> write_busy && q.tmr == TMR_RST)
    else $error("stop after write data did not start write cycle");

  write_len_a: assert property (
    write_busy |-> q.tmr < WR_CYCLES)
    else $error("write cycle overran");

  write_quiet_a: assert property (
    write_busy |-> !sda_oe && !q.ack_pend && !$rose(q.in_ack))
    else $error("activity during write cycle");

  addr_miss_a: assert property (
    q.st == ST_ADDR && last_bit && !addr_match && !start_ev && !stop_ev
      |=> standby ##1 !sda_oe)
    else $error("mismatched address not dropped");

  addr_hit_a: assert property (
    q.st == ST_ADDR && last_bit && addr_match && !start_ev && !stop_ev
      |=> q.ack_pend && q.rw == $past(word[RW_POS]))
    else $error("matched address not acknowledged");

  ignore_quiet_a: assert property (
    q.st == ST_IGNORE && !start_ev |=> !sda_oe && !q.ack_pend)
    else $error("ignoring device touched the bus");

  power_standby_a: assert property (
    $rose(standby) |-> $past(stop_ev) || $past(q.st) == ST_WRITE ||
                       $past(last_bit && !addr_match))
    else $error("standby entered unexpectedly");

  // Ack must stand through the ninth high phase, then let go
  ack_release_a: assert property (
    q.in_ack && fall_ev && q.cnt == CNT_RST && !q.ack_pend && !start_ev && !stop_ev
      |=> !sda_oe && !q.in_ack)
    else $error("ack not released after ninth clock");

  read_quiet_a: assert property (
    q.st == ST_ADDR && q.in_ack && q.rw && fall_ev && q.cnt == CNT_RST &&
      !start_ev && !stop_ev |=> q.st == ST_IGNORE && !sda_oe)
    else $error("read address did not release the bus");

  full_nack_a: assert property (
    q.st == ST_DATA && last_bit && q.tail_v && !start_ev && !stop_ev |=> !q.ack_pend)
    else $error("word acknowledged into a full buffer");

  write_end_a: assert property (
    write_busy && q.tmr == WR_CYCLES - TMR_W'(1) |=> standby && !write_busy)
    else $error("write cycle did not end in standby");

  buf_hold_a: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("buffered word lost under stall");

  hit_c: cover property (q.st == ST_ADDR && last_bit && addr_match);
  miss_c: cover property (q.st == ST_ADDR && last_bit && !addr_match);
  write_done_c: cover property (write_busy ##1 !write_busy);
  full_c: cover property (q.tail_v && rx_valid && !rx_ready);
  read_c: cover property (q.st == ST_ADDR && q.in_ack && q.rw && fall_ev);

endmodule

//--- rtl/twe_pkg.sv
// Constants, state codes and timing for the two-wire EEPROM bus front end.
// Assumes a 200 MHz system clock and a serial clock of at most 1 MHz.
package twe_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_WR_MS       = 5;
  localparam int unsigned NS_PER_MS     = 1000000;
  // Longest time, so the count rounds down
  localparam int unsigned WR_CYCLES_DEF = (T_WR_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 20;

  localparam int unsigned WORD_BITS     = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  DEV_PREAMBLE  = 4'hA;
  localparam int unsigned PRE_MSB       = 7;
  localparam int unsigned PRE_LSB       = 4;
  localparam int unsigned CS_MSB        = 3;
  localparam int unsigned CS_LSB        = 1;
  localparam int unsigned RW_POS        = 0;

  localparam logic [3:0]  CNT_RST       = 4'h0;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [2:0]  CS_RST        = 3'h0;
  localparam logic [TMR_W-1:0] TMR_RST  = 20'h00000;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_ADDR    = 3'b001,
    ST_DATA    = 3'b010,
    ST_IGNORE  = 3'b011,
    ST_WRITE   = 3'b100
  } twe_state_t;

endpackage

//--- test/twe_master.sv
// Behavioural two-wire bus master for the front-end bench.
// Assumes the bench builds the pulled-up data wire; paced by clk falling edges.
module twe_master (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Phase at the 100 clk minimum (500 ns); a bit takes three phases, one high and two low, so a 1500 ns link clock
  localparam int HALF = 100;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hc;
    repeat (HALF) @(negedge clk);
  endtask

  // start, data falls with clock high
  task automatic start;
    sda_low = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    sda_low = 1'b1;
    hc();
    scl = 1'b0;
    hc();
  endtask

  task automatic stop;
    sda_low = 1'b1;
    hc();
    scl = 1'b1;
    hc();
    sda_low = 1'b0;
    hc();
  endtask

  // bit valid over rising edge, MSB first
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      hc();
      scl = 1'b1;
      hc();
      scl = 1'b0;
      hc();
    end
    sda_low = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    ack = !sda;
    scl = 1'b0;
    hc();
  endtask

  task automatic recover;
    sda_low = 1'b0;
    repeat (9) begin
      hc();
      scl = 1'b1;
      hc();
      scl = 1'b0;
    end
    start();
  endtask
endmodule

//--- test/two_wire_eeprom_bus_front_end_bench.sv
// Self-checking bench: bus master model on the pins, queue model of the receive path.
// Assumes a pull-up on the data wire; select pins driven 0 stand for floating ones.
module two_wire_eeprom_bus_front_end_bench import twe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WR = 3000;
  logic        clk, rst_n, scl, m_low, sda_i, sda_o, sda_oe;
  logic        rx_valid, standby, write_busy, ack;
  logic        rx_ready = 1'b0;
  logic        rdy_en   = 1'b1;
  logic [2:0]  cs;
  logic [7:0]  rx_data, a;
  logic [31:0] lf = 32'hF96A;
  logic [31:0] lr = 32'hF96A;
  logic [7:0]  q[$];
  int          n_mismatch = 0, checks = 0, cyc = 0, bc = 0, last_bc = 0;

  assign sda_i = !(m_low || sda_oe);

  twe_front_end #(.WR_CYCLES(TMR_W'(WR))) uut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .standby(standby),
    .write_busy(write_busy));
  twe_master m (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda_i));

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Acked data words join the model queue before their bits go out:
  // the design may hand a word on before its ack clock is over
  task automatic send(input logic [7:0] b, input logic exp, input logic dat);
    if (exp && dat) q.push_back(b);
    m.wr_byte(b, ack);
    check(ack, exp);
  endtask

  task automatic wait_idle;
    for (int n = 0; n < 20000 && write_busy !== 1'b0; n++) @(negedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) begin
    lr = nx(lr);
    rx_ready <= rdy_en & lr[4];
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      print_verdict();
    end
    if (rst_n) begin
      if (rx_valid && rx_ready) check(rx_data, q.pop_front());
      if (sda_oe) check(sda_o, 8'h00);
      if (write_busy) bc++;
      else if (bc != 0) begin
        last_bc = bc;
        bc = 0;
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    cs    = 3'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check({sda_oe, rx_valid, write_busy, standby}, 8'h01);
    for (int k = 0; k < 8; k++) begin
      cs = k[2:0];
      lf = nx(lf);
      a = {DEV_PREAMBLE, (k[0] ? lf[2:0] : cs), lf[3]};
      m.start();
      send(a, a[3:1] == cs, 1'b0);
      m.stop();
      check({write_busy, standby}, 8'h01);
    end
    // Stalled receiver: third word finds the buffer full
    rdy_en = 1'b0;
    cs = lf[6:4];
    a = {DEV_PREAMBLE, cs, 1'b0};
    m.start();
    send(a, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      send(lf[7:0], q.size() < 2, 1'b1);
    end
    m.stop();
    check({write_busy, standby}, 8'h02);
    m.start();
    send(a, 1'b0, 1'b0);
    m.stop();
    rdy_en = 1'b1;
    wait_idle();
    check(8'(last_bc >= WR - 1 && last_bc <= WR + 1), 8'h01);
    check(standby, 1'b1);
    m.start();
    send({~DEV_PREAMBLE, cs, 1'b0}, 1'b0, 1'b0);
    check(standby, 1'b1);
    send(8'h00, 1'b0, 1'b0);
    m.stop();
    check({write_busy, standby}, 8'h01);
    m.start();
    send({DEV_PREAMBLE, cs, 1'b1}, 1'b1, 1'b0);
    m.recover();
    send(a, 1'b1, 1'b0);
    lf = nx(lf);
    send(lf[7:0], 1'b1, 1'b1);
    m.stop();
    wait_idle();
    check(8'(q.size()), 8'h00);
    print_verdict();
  end
endmodule
